// File: rtl/mhb_params.svh
// Offsets, field positions, reset values and mode masks of the header block
`ifndef MHB_PARAMS_SVH
`define MHB_PARAMS_SVH

// ----------------------------------------------------------------------------
// Header word byte offsets
// ----------------------------------------------------------------------------
`define MHB_OFF_ERR_HI      8'h0a
`define MHB_OFF_START_PTR   8'h0e
`define MHB_OFF_STOP_PTR    8'h10
`define MHB_OFF_START_PAGE  8'h12
`define MHB_OFF_STOP_PAGE   8'h14
`define MHB_OFF_MASK_A      8'h16
`define MHB_OFF_MASK_B      8'h18
`define MHB_OFF_SUPPRESS    8'h1a
`define MHB_OFF_MC_LOW      8'h1c
`define MHB_OFF_MC_HIGH     8'h1e

// ----------------------------------------------------------------------------
// Reset values and field layout
// ----------------------------------------------------------------------------
`define MHB_RST_WORD        16'h0000
`define MHB_RST_PAGE        4'h0
`define MHB_PAGE_MSB        3
`define MHB_SUPPRESS_USED   16'h7fff
`define MHB_CTL_SIM_BIT     9
`define MHB_CTL_MON_BIT     8
`define MHB_FIRST_HI_WORD   6'h11
`define MHB_LAST_HI_WORD    6'h20
`define MHB_RING_STEP       20'h00002

// ----------------------------------------------------------------------------
// Interrupt mask bit positions
// ----------------------------------------------------------------------------
`define MHB_IRQ_TX_ERROR    15
`define MHB_IRQ_DMA_ERROR   14
`define MHB_IRQ_PAGE_FULL   13
`define MHB_IRQ_END_MSG     12
`define MHB_IRQ_PROG_ERROR  11
`define MHB_IRQ_RING_FULL   10
`define MHB_IRQ_STOP        9
`define MHB_IRQ_LOCK_LOST   8
`define MHB_IRQ_ILLEGAL_CMD 7
`define MHB_IRQ_CMD_TRIGGER 6
`define MHB_IRQ_MODE_CODE   5
`define MHB_IRQ_RETRY_OK    4
`define MHB_IRQ_RETRY_FAIL  3
`define MHB_IRQ_BIT_FAIL    2
`define MHB_IRQ_BIT_COMPARE 1
`define MHB_IRQ_SECONDARY   0

// ----------------------------------------------------------------------------
// Transfer suppress bits honoured per operating mode
// ----------------------------------------------------------------------------
`define MHB_SUP_MASK_MRT    16'h7010
`define MHB_SUP_MASK_MON    16'h70f0
`define MHB_SUP_MASK_BC     16'h4fef

`endif

// File: rtl/mhb_pkg.sv
// Types shared by the header block and its terminal table
package mhb_pkg;

  typedef enum logic [1:0] {
    MHB_MODE_BC,
    MHB_MODE_MRT,
    MHB_MODE_MON
  } mhb_mode_e;

  typedef enum logic {
    MHB_RING_IDLE,
    MHB_RING_RUN
  } mhb_ring_e;

  typedef struct packed {
    logic [15:0] mask_a;
    logic [15:0] mask_b;
    logic        sim;
    logic        mon;
  } mhb_term_s;

endpackage

// File: rtl/mhb_term_if.sv
// Carrier between the header block and its per-terminal table
interface mhb_term_if
  import mhb_pkg::*;
#(
  parameter int AW = 5
);
  logic            wr_en;
  logic [AW-1:0]   wr_addr;
  mhb_term_s       wr_data;
  logic [AW-1:0]   rd_addr;
  mhb_term_s       rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr,
                input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr,
                output rd_data);
endinterface

// File: rtl/mhb_term_mem.sv
// Per-terminal mask and activity table with registered read
module mhb_term_mem
  import mhb_pkg::*;
#(
  parameter int DEPTH = 32,
  parameter int AW    = 5
)
(
  input  wire logic   clk,
  input  wire logic   rst_n,
  mhb_term_if.mem     term
);

  mhb_term_s table_ff [DEPTH];

  initial
  begin
    if (DEPTH != (1 << AW))
      $error("mhb_term_mem: DEPTH must equal 2**AW");
  end

  // --------------------------------------------------------------------------
  // Storage, cleared so unwritten terminals stay inactive
  // --------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        table_ff[i] <= '0;
    end
    else if (term.wr_en)
    begin
      table_ff[term.wr_addr] <= term.wr_data;
    end
  end

  // --------------------------------------------------------------------------
  // Registered read port
  // --------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      term.rd_data <= '0;
    else
      term.rd_data <= table_ff[term.rd_addr];
  end

endmodule // mhb_term_mem

// File: rtl/mhb_header_block.sv
// Header control words of the multi-terminal and monitor engine
//
// Overview of operation
// - Second error word select bit 0..15 marks data words 17..32, for all terminals.
// - Ring begin/end words bound the capture ring, used only in monitor mode.
// - Ring start address is begin map bits 3:0 over begin pointer.
// - Ring end address is end map bits 3:0 over end pointer.
// - Header interrupt masks are ORed into every terminal's own mask.
// - Interrupt raised when effective mask and status share a set bit and the terminal is active (sim or mon bit set).
// - Mask bits 15..8: transmit, transfer, page full, end, program, ring, stop, lock.
// - Mask bits 7..0: illegal, trigger, mode code, retry, bus switch, self test, secondary.
// - Each suppress bit honoured in the current mode blocks its transfer for all terminals; bit 15 reads zero.
// - Multi-terminal/monitor: bits 14,13,12,4 block gap, time tags, new data pointer.
// - Controller/monitor: bit 7 response time, bits 6 and 5 status words.
// - Controller: bits 11..8, 3..0 block retry, interrupt, status mask, error fetches.
// - First mode code enable word: bit n enables mode code n.
// - Second mode code enable word: bit n enables mode code n plus 16.
// - One block per terminal, or one shared block when all-terminal option set.
// - A terminal block applies to the terminal address it carries.
// - Terminal blocks accepted in any order and any mix.
// - Terminal masks ORed with header masks form the final masks.
`include "mhb_params.svh"

module mhb_header_block
  import mhb_pkg::*;
#(
  parameter int TERMINALS = 32
)
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic        HOST_WR,
  input  wire logic        HOST_RD,
  input  wire logic [7:0]  HOST_ADDR,
  input  wire logic [15:0] HOST_WDATA,
  output logic      [15:0] HOST_RDATA,
  output logic             HOST_RVALID,
  input  mhb_mode_e        MODE,
  input  wire logic        ALL_TERMINALS,
  input  wire logic        TB_WR,
  input  wire logic [4:0]  TB_TERMINAL_ADDR,
  input  wire logic [15:0] TB_CONTROL_WORD,
  input  wire logic [15:0] TB_MASK_A,
  input  wire logic [15:0] TB_MASK_B,
  input  wire logic        EVT_VALID,
  input  wire logic [4:0]  EVT_TERMINAL_ADDR,
  input  wire logic [15:0] EVT_STATUS,
  input  wire logic [5:0]  WORD_NUM,
  output logic             WORD_ERR_HI,
  output logic      [15:0] ERR_WORD_SEL_HI,
  input  wire logic        CAP_WR,
  output logic      [19:0] RING_START,
  output logic      [19:0] RING_STOP,
  output logic      [19:0] RING_ADDR,
  output logic             RING_WRAP,
  output logic      [15:0] SUPPRESS,
  output logic      [31:0] MODE_CODE_EN,
  output logic             IRQ_A,
  output logic             IRQ_B,
  output logic      [4:0]  IRQ_TERMINAL_ADDR,
  output logic      [15:0] IRQ_CAUSE_A,
  output logic      [15:0] IRQ_CAUSE_B
);

  localparam int AW = $clog2(TERMINALS);

  initial
  begin
    if (TERMINALS < 2 || TERMINALS > 32 || (TERMINALS & (TERMINALS - 1)) != 0)
      $error("mhb_header_block: TERMINALS must be a power of two, 2 to 32");
  end

  // --------------------------------------------------------------------------
  // Header words
  // --------------------------------------------------------------------------
  logic [15:0] err_hi_ff;
  logic [15:0] start_ptr_ff;
  logic [15:0] stop_ptr_ff;
  logic [3:0]  start_page_ff;
  logic [3:0]  stop_page_ff;
  logic [15:0] mask_a_ff;
  logic [15:0] mask_b_ff;
  logic [15:0] suppress_word_ff;
  logic [15:0] mc_low_ff;
  logic [15:0] mc_high_ff;

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      err_hi_ff        <= `MHB_RST_WORD;
      start_ptr_ff     <= `MHB_RST_WORD;
      stop_ptr_ff      <= `MHB_RST_WORD;
      start_page_ff    <= `MHB_RST_PAGE;
      stop_page_ff     <= `MHB_RST_PAGE;
      mask_a_ff        <= `MHB_RST_WORD;
      mask_b_ff        <= `MHB_RST_WORD;
      suppress_word_ff <= `MHB_RST_WORD;
      mc_low_ff        <= `MHB_RST_WORD;
      mc_high_ff       <= `MHB_RST_WORD;
    end
    else if (HOST_WR)
    begin
      case (HOST_ADDR)
        `MHB_OFF_ERR_HI:     err_hi_ff     <= HOST_WDATA;
        `MHB_OFF_START_PTR:  start_ptr_ff  <= HOST_WDATA;
        `MHB_OFF_STOP_PTR:   stop_ptr_ff   <= HOST_WDATA;
        `MHB_OFF_START_PAGE: start_page_ff <= HOST_WDATA[`MHB_PAGE_MSB:0];
        `MHB_OFF_STOP_PAGE:  stop_page_ff  <= HOST_WDATA[`MHB_PAGE_MSB:0];
        `MHB_OFF_MASK_A:     mask_a_ff     <= HOST_WDATA;
        `MHB_OFF_MASK_B:     mask_b_ff     <= HOST_WDATA;
        `MHB_OFF_SUPPRESS:   suppress_word_ff <= HOST_WDATA & `MHB_SUPPRESS_USED;
        `MHB_OFF_MC_LOW:     mc_low_ff     <= HOST_WDATA;
        `MHB_OFF_MC_HIGH:    mc_high_ff    <= HOST_WDATA;
        default:             ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Host read-back
  // --------------------------------------------------------------------------
  logic [15:0] nxt_rdata;

  always_comb
  begin
    case (HOST_ADDR)
      `MHB_OFF_ERR_HI:     nxt_rdata = err_hi_ff;
      `MHB_OFF_START_PTR:  nxt_rdata = start_ptr_ff;
      `MHB_OFF_STOP_PTR:   nxt_rdata = stop_ptr_ff;
      `MHB_OFF_START_PAGE: nxt_rdata = {12'h000, start_page_ff};
      `MHB_OFF_STOP_PAGE:  nxt_rdata = {12'h000, stop_page_ff};
      `MHB_OFF_MASK_A:     nxt_rdata = mask_a_ff;
      `MHB_OFF_MASK_B:     nxt_rdata = mask_b_ff;
      `MHB_OFF_SUPPRESS:   nxt_rdata = suppress_word_ff;
      `MHB_OFF_MC_LOW:     nxt_rdata = mc_low_ff;
      `MHB_OFF_MC_HIGH:    nxt_rdata = mc_high_ff;
      default:             nxt_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      HOST_RDATA  <= 16'h0000;
      HOST_RVALID <= 1'b0;
    end
    else
    begin
      HOST_RDATA  <= HOST_RD ? nxt_rdata : 16'h0000;
      HOST_RVALID <= HOST_RD;
    end
  end

  // --------------------------------------------------------------------------
  // Error word selects for data words 17 to 32
  // --------------------------------------------------------------------------
  logic [5:0] word_ofs;
  logic       nxt_word_err_hi;

  assign word_ofs = WORD_NUM - `MHB_FIRST_HI_WORD;

  always_comb
  begin
    if (WORD_NUM >= `MHB_FIRST_HI_WORD && WORD_NUM <= `MHB_LAST_HI_WORD)
      nxt_word_err_hi = err_hi_ff[word_ofs[3:0]];
    else
      nxt_word_err_hi = 1'b0;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      WORD_ERR_HI     <= 1'b0;
      ERR_WORD_SEL_HI <= 16'h0000;
    end
    else
    begin
      WORD_ERR_HI     <= nxt_word_err_hi;
      ERR_WORD_SEL_HI <= err_hi_ff;
    end
  end

  // --------------------------------------------------------------------------
  // Monitor capture ring
  // --------------------------------------------------------------------------
  mhb_ring_e   ring_state_ff;
  logic [19:0] start_addr;
  logic [19:0] stop_addr;

  assign start_addr = {start_page_ff, start_ptr_ff};
  assign stop_addr  = {stop_page_ff, stop_ptr_ff};

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      ring_state_ff <= MHB_RING_IDLE;
      RING_ADDR     <= 20'h00000;
      RING_WRAP     <= 1'b0;
    end
    else
    begin
      RING_WRAP <= 1'b0;
      case (ring_state_ff)
        MHB_RING_IDLE:
        begin
          RING_ADDR <= start_addr;
          // Ring only runs in monitor mode
          if (MODE == MHB_MODE_MON)
            ring_state_ff <= MHB_RING_RUN;
        end
        MHB_RING_RUN:
        begin
          if (MODE != MHB_MODE_MON)
            ring_state_ff <= MHB_RING_IDLE;
          else if (CAP_WR)
          begin
            if (RING_ADDR == stop_addr)
            begin
              RING_ADDR <= start_addr;
              RING_WRAP <= 1'b1;
            end
            else
            begin
              RING_ADDR <= RING_ADDR + `MHB_RING_STEP;
            end
          end
        end
        default:
        begin
          ring_state_ff <= MHB_RING_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      RING_START <= 20'h00000;
      RING_STOP  <= 20'h00000;
    end
    else
    begin
      RING_START <= start_addr;
      RING_STOP  <= stop_addr;
    end
  end

  // --------------------------------------------------------------------------
  // Transfer suppression by mode
  // --------------------------------------------------------------------------
  logic [15:0] mode_sup_mask;

  always_comb
  begin
    case (MODE)
      // Gap, time tags, new data pointer
      MHB_MODE_MRT: mode_sup_mask = `MHB_SUP_MASK_MRT;
      // Adds response time and status words
      MHB_MODE_MON: mode_sup_mask = `MHB_SUP_MASK_MON;
      MHB_MODE_BC:  mode_sup_mask = `MHB_SUP_MASK_BC;
      default:      mode_sup_mask = 16'h0000;
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      SUPPRESS <= 16'h0000;
    else
      SUPPRESS <= suppress_word_ff & mode_sup_mask;
  end

  // --------------------------------------------------------------------------
  // Mode code enables
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      MODE_CODE_EN <= 32'h00000000;
    else
      MODE_CODE_EN <= {mc_high_ff, mc_low_ff};
  end

  // --------------------------------------------------------------------------
  // Per-terminal blocks
  // --------------------------------------------------------------------------
  mhb_term_if #(.AW(AW)) term ();

  logic [AW-1:0] common_ta_ff;

  mhb_term_mem #(
    .DEPTH (TERMINALS),
    .AW    (AW)
  ) u_term_mem (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .term  (term.mem)
  );

  // Stored at the carried address, any order
  assign term.wr_en        = TB_WR;
  assign term.wr_addr      = TB_TERMINAL_ADDR[AW-1:0];
  assign term.wr_data      = '{mask_a: TB_MASK_A,
                               mask_b: TB_MASK_B,
                               sim:    TB_CONTROL_WORD[`MHB_CTL_SIM_BIT],
                               mon:    TB_CONTROL_WORD[`MHB_CTL_MON_BIT]};
  assign term.rd_addr      = ALL_TERMINALS ? common_ta_ff : EVT_TERMINAL_ADDR[AW-1:0];

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      common_ta_ff <= '0;
    else if (TB_WR)
      common_ta_ff <= TB_TERMINAL_ADDR[AW-1:0];
  end

  // --------------------------------------------------------------------------
  // Interrupt evaluation, two stages
  // --------------------------------------------------------------------------
  logic        evt_ff;
  logic [4:0]  evt_ta_ff;
  logic [15:0] evt_status_ff;
  logic [15:0] eff_mask_a;
  logic [15:0] eff_mask_b;
  logic        term_active;

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      evt_ff        <= 1'b0;
      evt_ta_ff     <= 5'h00;
      evt_status_ff <= 16'h0000;
    end
    else
    begin
      evt_ff        <= EVT_VALID;
      evt_ta_ff     <= EVT_TERMINAL_ADDR;
      evt_status_ff <= EVT_STATUS;
    end
  end

  // Header masks ORed into terminal masks
  assign eff_mask_a  = mask_a_ff | term.rd_data.mask_a;
  assign eff_mask_b  = mask_b_ff | term.rd_data.mask_b;
  assign term_active = term.rd_data.sim | term.rd_data.mon;

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      IRQ_A             <= 1'b0;
      IRQ_B             <= 1'b0;
      IRQ_TERMINAL_ADDR <= 5'h00;
      IRQ_CAUSE_A       <= 16'h0000;
      IRQ_CAUSE_B       <= 16'h0000;
    end
    else if (evt_ff && term_active)
    begin
      // Any common set bit raises the level
      // Cause bits keep their mask meaning
      IRQ_A             <= |(eff_mask_a & evt_status_ff);
      IRQ_B             <= |(eff_mask_b & evt_status_ff);
      IRQ_TERMINAL_ADDR <= evt_ta_ff;
      IRQ_CAUSE_A       <= eff_mask_a & evt_status_ff;
      IRQ_CAUSE_B       <= eff_mask_b & evt_status_ff;
    end
    else
    begin
      IRQ_A             <= 1'b0;
      IRQ_B             <= 1'b0;
      IRQ_CAUSE_A       <= 16'h0000;
      IRQ_CAUSE_B       <= 16'h0000;
    end
  end

endmodule // mhb_header_block

// File: sim/mhb_host_model.sv
// Host side model that writes and reads header words one at a time
module mhb_host_model
(
  input  wire logic        clk,
  output logic             host_wr,
  output logic             host_rd,
  output logic      [7:0]  host_addr,
  output logic      [15:0] host_wdata,
  input  wire logic [15:0] host_rdata,
  input  wire logic        host_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 8'hff;
    host_wdata = 16'hffff;
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    @(posedge clk);
    #1;
    host_wr = 1'b0;
    host_addr = ~a;
    host_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    #1;
    host_rd = 1'b1;
    host_addr = a;
    @(posedge clk);
    #1;
    host_rd = 1'b0;
    host_addr = ~a;
    d = host_rvalid ? host_rdata : 16'hxxxx;
  endtask
endmodule // mhb_host_model

// File: sim/mhb_header_block_sva.sv
// Port assertions of the header block
`include "mhb_params.svh"

module mhb_header_block_sva
  import mhb_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic        HOST_WR,
  input  wire logic [7:0]  HOST_ADDR,
  input  wire logic [15:0] HOST_WDATA,
  input  mhb_mode_e        MODE,
  input  wire logic        EVT_VALID,
  input  wire logic [4:0]  EVT_TERMINAL_ADDR,
  input  wire logic [15:0] EVT_STATUS,
  input  wire logic [5:0]  WORD_NUM,
  input  wire logic        WORD_ERR_HI,
  input  wire logic [15:0] ERR_WORD_SEL_HI,
  input  wire logic        CAP_WR,
  input  wire logic [19:0] RING_START,
  input  wire logic [19:0] RING_STOP,
  input  wire logic [19:0] RING_ADDR,
  input  wire logic        RING_WRAP,
  input  wire logic [15:0] SUPPRESS,
  input  wire logic        IRQ_A,
  input  wire logic [4:0]  IRQ_TERMINAL_ADDR,
  input  wire logic [15:0] IRQ_CAUSE_A
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  a_word_hi_sel: assert property (
    WORD_NUM inside {[6'h11:6'h20]} |=> WORD_ERR_HI == ERR_WORD_SEL_HI[$past(WORD_NUM) - 6'h11])
    else $error("high word select wrong");
  a_start_page: assert property (
    HOST_WR && HOST_ADDR == 8'h12 |=> ##1 RING_START[19:16] == $past(HOST_WDATA[3:0], 2))
    else $error("ring start page wrong");
  a_stop_ptr: assert property (
    HOST_WR && HOST_ADDR == 8'h10 |=> ##1 RING_STOP[15:0] == $past(HOST_WDATA, 2))
    else $error("ring stop pointer wrong");
  a_suppress_mode: assert property (
    (SUPPRESS & ~($past(MODE) == MHB_MODE_BC ? `MHB_SUP_MASK_BC :
      $past(MODE) == MHB_MODE_MRT ? `MHB_SUP_MASK_MRT : `MHB_SUP_MASK_MON)) == 16'h0000)
    else $error("suppress bit outside mode");
  a_cause_subset: assert property (
    EVT_VALID |-> ##2 (IRQ_CAUSE_A & ~$past(EVT_STATUS, 2)) == 16'h0000 && IRQ_A == |IRQ_CAUSE_A)
    else $error("level A cause wrong");
  a_irq_term: assert property (
    EVT_VALID ##2 IRQ_A |-> IRQ_TERMINAL_ADDR == $past(EVT_TERMINAL_ADDR, 2))
    else $error("interrupt terminal wrong");
  a_ring_step: assert property (
    CAP_WR && MODE == MHB_MODE_MON && $past(MODE) == MHB_MODE_MON && RING_ADDR != RING_STOP
      |=> RING_ADDR == $past(RING_ADDR) + 20'h00002 && !RING_WRAP)
    else $error("capture step wrong");
  a_ring_wrap: assert property (
    CAP_WR && MODE == MHB_MODE_MON && $past(MODE) == MHB_MODE_MON && RING_ADDR == RING_STOP
      |=> RING_WRAP && RING_ADDR == RING_START)
    else $error("capture wrap wrong");
endmodule // mhb_header_block_sva

bind mhb_header_block mhb_header_block_sva u_mhb_header_block_sva (
  .CLK_SYS, .RST_N, .HOST_WR, .HOST_ADDR, .HOST_WDATA, .MODE, .EVT_VALID,
  .EVT_TERMINAL_ADDR, .EVT_STATUS, .WORD_NUM, .WORD_ERR_HI, .ERR_WORD_SEL_HI, .CAP_WR,
  .RING_START, .RING_STOP, .RING_ADDR, .RING_WRAP, .SUPPRESS, .IRQ_A,
  .IRQ_TERMINAL_ADDR, .IRQ_CAUSE_A);

// File: sim/mhb_header_block_tb.sv
// Bench for the header block: host words, terminal blocks, events, capture
module mhb_header_block_tb
  import mhb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'b0, rst_n = 1'b0, host_wr, host_rd, host_rvalid;
  logic [7:0]  host_addr;
  logic [15:0] host_wdata, host_rdata, d, e;
  mhb_mode_e   mode = MHB_MODE_BC;
  logic        all_t = 1'b0, tb_wr = 1'b0, evt_valid = 1'b0, cap_wr = 1'b0;
  logic [4:0]  tb_ta = 5'h00, evt_ta = 5'h00, irq_ta, last_ta = 5'h00;
  logic [15:0] tb_ctl = 16'h0000, tb_ma = 16'h0000, tb_mb = 16'h0000, evt_st = 16'h0000;
  logic [15:0] err_sel, sup, cause_a, cause_b;
  logic [5:0]  word_num = 6'h00;
  logic        word_err, wrap, irq_a, irq_b;
  logic [19:0] r_start, r_stop, r_addr;
  logic [31:0] mc_en;
  logic [7:0]  offs [10] = '{8'h0a, 8'h0e, 8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1a, 8'h1c, 8'h1e};
  logic [5:0]  wn [4] = '{6'h11, 6'h20, 6'h12, 6'h10};
  mhb_mode_e   ms [3] = '{MHB_MODE_BC, MHB_MODE_MRT, MHB_MODE_MON};
  logic [15:0] sx [3] = '{16'h4fef, 16'h7010, 16'h70f0};
  int          num_errors = 0, checks_done = 0, cycles = 0;

  mhb_header_block u_mhb_header_block (
    .CLK_SYS(clk), .RST_N(rst_n), .HOST_WR(host_wr), .HOST_RD(host_rd),
    .HOST_ADDR(host_addr), .HOST_WDATA(host_wdata), .HOST_RDATA(host_rdata),
    .HOST_RVALID(host_rvalid), .MODE(mode), .ALL_TERMINALS(all_t), .TB_WR(tb_wr),
    .TB_TERMINAL_ADDR(tb_ta), .TB_CONTROL_WORD(tb_ctl), .TB_MASK_A(tb_ma),
    .TB_MASK_B(tb_mb), .EVT_VALID(evt_valid), .EVT_TERMINAL_ADDR(evt_ta),
    .EVT_STATUS(evt_st), .WORD_NUM(word_num), .WORD_ERR_HI(word_err),
    .ERR_WORD_SEL_HI(err_sel), .CAP_WR(cap_wr), .RING_START(r_start), .RING_STOP(r_stop),
    .RING_ADDR(r_addr), .RING_WRAP(wrap), .SUPPRESS(sup), .MODE_CODE_EN(mc_en),
    .IRQ_A(irq_a), .IRQ_B(irq_b), .IRQ_TERMINAL_ADDR(irq_ta), .IRQ_CAUSE_A(cause_a),
    .IRQ_CAUSE_B(cause_b));

  mhb_host_model u_mhb_host_model (
    .clk, .host_wr, .host_rd, .host_addr, .host_wdata, .host_rdata, .host_rvalid);

  always #5 clk = ~clk;

  // ----------------------------------------
  // Run control and shared tasks
  // ----------------------------------------
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      num_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic hw(input logic [7:0] a, input logic [15:0] x);
    u_mhb_host_model.wr(a, x);
  endtask

  task automatic hr(input logic [7:0] a, output logic [15:0] x);
    u_mhb_host_model.rd(a, x);
  endtask

  task automatic tbw(input logic [4:0] ta, input logic [15:0] c, a, b);
    tick();
    tb_wr = 1'b1;
    tb_ta = ta;
    tb_ctl = c;
    tb_ma = a;
    tb_mb = b;
    tick();
    tb_wr = 1'b0;
  endtask

  // Event taken at one edge, interrupt launched at the next
  task automatic evt(input logic [4:0] ta, input logic [15:0] st, ea, eb);
    tick();
    evt_valid = 1'b1;
    evt_ta = ta;
    evt_st = st;
    tick();
    evt_valid = 1'b0;
    evt_st = ~st;
    tick();
    if ((ea | eb) != 16'h0000)
      last_ta = ta;
    chk({irq_ta, irq_a, irq_b, cause_a, cause_b}, {last_ta, |ea, |eb, ea, eb});
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    foreach (offs[i])
    begin
      hr(offs[i], d);
      chk({24'h0, d}, 40'h0);
      hw(offs[i], 16'hffff);
      hr(offs[i], d);
      e = offs[i] inside {8'h12, 8'h14} ? 16'h000f : offs[i] == 8'h1a ? 16'h7fff : 16'hffff;
      chk({24'h0, d}, {24'h0, e});
    end
    hw(8'h20, 16'h1234);
    hr(8'h20, d);
    chk({24'h0, d}, 40'h0);
    hw(8'h0a, 16'h8001);
    foreach (wn[i])
    begin
      word_num = wn[i];
      tick();
      tick();
      chk({23'h0, word_err, err_sel}, {23'h0, i < 2, 16'h8001});
    end
    foreach (ms[i])
    begin
      mode = ms[i];
      tick();
      tick();
      chk({24'h0, sup}, {24'h0, sx[i]});
    end
    mode = MHB_MODE_BC;
    hw(8'h1c, 16'h0001);
    hw(8'h1e, 16'h8000);
    hw(8'h0e, 16'h0100);
    hw(8'h12, 16'h0005);
    hw(8'h10, 16'h0104);
    hw(8'h14, 16'h0005);
    tick();
    tick();
    chk({8'h0, mc_en}, 40'h0080000001);
    chk({r_start, r_stop}, 40'h5010050104);
    cap_wr = 1'b1;
    tick();
    cap_wr = 1'b0;
    chk({20'h0, r_addr}, 40'h50100);
    mode = MHB_MODE_MON;
    tick();
    tick();
    cap_wr = 1'b1;
    for (int i = 1; i < 4; i++)
    begin
      tick();
      chk({19'h0, wrap, r_addr}, 40'h50100 + (i == 3 ? 40'h100000 : 40'(2 * i)));
    end
    cap_wr = 1'b0;
    mode = MHB_MODE_MRT;
    hw(8'h16, 16'h8000);
    hw(8'h18, 16'h0100);
    tbw(5'h07, 16'h0100, 16'h0002, 16'h0000);
    tbw(5'h02, 16'h0200, 16'h0004, 16'h0010);
    evt(5'h07, 16'hffff, 16'h8002, 16'h0100);
    evt(5'h02, 16'hffff, 16'h8004, 16'h0110);
    evt(5'h09, 16'hffff, 16'h0000, 16'h0000);
    evt(5'h02, 16'h0003, 16'h0000, 16'h0000);
    for (int i = 0; i < 16; i++)
      evt(5'h02, 16'h1 << i, (16'h1 << i) & 16'h8004, (16'h1 << i) & 16'h0110);
    all_t = 1'b1;
    evt(5'h09, 16'hffff, 16'h8004, 16'h0110);
    all_t = 1'b0;
    end_sim();
  end
endmodule // mhb_header_block_tb
